// >>> core/accr_pkg.sv
// Package for the channel configuration register bank.
// Assumes a byte-wide register port with page and address, one clock mclk.
package accr_pkg;

  // ***************************************************************
  // Register page and offsets
  // ***************************************************************
  localparam logic [7:0] ACCR_PAGE_CFG = 8'h00; // Page holding the bank
  localparam logic [7:0] ACCR_OFS_CH3_GAIN_TRIM = 8'h49; // Channel 3 gain trim
  localparam logic [7:0] ACCR_OFS_CH3_PHASE_TRIM = 8'h4A; // Channel 3 phase trim
  localparam logic [7:0] ACCR_OFS_CH4_INPUT_SETUP = 8'h4B; // Channel 4 input setup
  localparam logic [7:0] ACCR_OFS_CH4_ANALOG_GAIN = 8'h4C; // Channel 4 analog gain
  localparam logic [7:0] ACCR_OFS_CH4_VOLUME = 8'h4D; // Channel 4 volume

  // ***************************************************************
  // Reset values and writable bit masks
  // ***************************************************************
  localparam logic [7:0] ACCR_RST_GAIN_TRIM = 8'h80; // Trim code 8 in upper nibble
  localparam logic [7:0] ACCR_RST_PHASE_TRIM = 8'h00; // No added delay
  localparam logic [7:0] ACCR_RST_INPUT_SETUP = 8'h00; // Mic, differential, AC
  localparam logic [7:0] ACCR_RST_ANALOG_GAIN = 8'h00; // 0 dB
  localparam logic [7:0] ACCR_RST_VOLUME = 8'hC9; // 0 dB volume
  localparam logic [7:0] ACCR_MASK_GAIN_TRIM = 8'hF0; // Bits 3-0 reserved
  localparam logic [7:0] ACCR_MASK_INPUT_SETUP = 8'hFD; // Bit 1 reserved
  localparam logic [7:0] ACCR_MASK_ANALOG_GAIN = 8'hFC; // Bits 1-0 reserved
  localparam logic [7:0] ACCR_MASK_FULL = 8'hFF; // Fully writable

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int ACCR_POS_TRIM_LSB = 4; // Gain trim code bits 7-4
  localparam int ACCR_POS_LINE = 7; // Line/mic select
  localparam int ACCR_POS_SRC_LSB = 5; // Source select bits 6-5
  localparam int ACCR_POS_DC = 4; // Coupling select
  localparam int ACCR_POS_IMP_LSB = 2; // Impedance select bits 3-2
  localparam int ACCR_POS_RBOOST = 0; // Range boost enable
  localparam int ACCR_POS_GAIN_LSB = 2; // Gain code bits 7-2

  // ***************************************************************
  // Codes and decode constants
  // ***************************************************************
  localparam logic [1:0] ACCR_SRC_ANALOG_DIFF = 2'h0; // Analog differential
  localparam logic [1:0] ACCR_SRC_ANALOG_SE = 2'h1; // Analog single ended
  localparam logic [1:0] ACCR_SRC_DENSITY_MIC = 2'h2; // Pulse density mic
  localparam logic [4:0] ACCR_TRIM_ZERO = 5'h08; // Trim code for 0 dB
  localparam logic [8:0] ACCR_VOL_ZERO = 9'h0C9; // Volume code for 0 dB
  localparam logic [7:0] ACCR_VOL_MUTE = 8'h00; // Volume code that mutes

  // Decoded channel settings handed to the datapaths
  typedef struct packed {
    logic lineInput; // 1: line input, 0: microphone
    logic [1:0] source; // Source select code
    logic dcCoupled; // DC coupling, analog sources only
    logic [1:0] impedance; // Impedance code, analog sources only
    logic rangeEnhancerOn; // Range enhancer active
    logic autoGainLoopOn; // Automatic gain loop active
    logic [5:0] gainDb; // Analog gain in 1 dB steps
    logic volMute; // Volume muted
    logic [8:0] volHalfDb; // Signed volume in 0.5 dB steps
    logic [4:0] ch3TrimTenths; // Signed channel 3 trim in 0.1 dB steps
  } accr_cfg_t;

endpackage : accr_pkg

// >>> core/accr_channel_regs.sv
// Register bank for channel 3 trims and channel 4 configuration.
// Assumes a synchronous byte register port and a modulator tick enable on mclk.
`timescale 1ns/10ps

module accr_channel_regs (
  input wire logic mclk, // System clock, 25 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [7:0] regPage, // Selected register page
  input wire logic [7:0] regAddr, // Register address
  input wire logic regWrEn, // Write strobe
  input wire logic [7:0] regWrData, // Write data
  input wire logic regRdEn, // Read strobe
  output logic [7:0] regRdData, // Read data, one cycle after strobe
  input wire logic gainLoopSelect, // Bit 3 of gain_loop_config_reg
  input wire logic modTick, // One pulse per modulator clock cycle
  input wire logic ch3SampleIn, // Channel 3 sampling event
  output logic ch3SampleOut, // Channel 3 sampling event after delay
  output accr_pkg::accr_cfg_t chanCfg // Decoded channel settings
);
  import accr_pkg::*;

  // ***************************************************************
  // Register storage
  // ***************************************************************
  logic [7:0] gainTrim; // chan3_gain_trim
  logic [7:0] phaseTrim; // chan3_phase_trim
  logic [7:0] inputSetup; // chan4_input_setup
  logic [7:0] analogGain; // chan4_analog_gain
  logic [7:0] volume; // chan4_volume
  logic pageHit; // Access targets the bank page

  // Address match on the offset only, page checked by pageHit
  function automatic logic accr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    accr_hit = (addr == ofs);
  endfunction : accr_hit

  // Keep only writable bits of a write
  function automatic logic [7:0] accr_mask(input logic [7:0] data, input logic [7:0] msk);
    accr_mask = data & msk;
  endfunction : accr_mask

  assign pageHit = (regPage == ACCR_PAGE_CFG);

  // ***************************************************************
  // Register writes
  // ***************************************************************
  // trim reset code
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gainTrim <= ACCR_RST_GAIN_TRIM;
    end else if (regWrEn && pageHit && accr_hit(regAddr, ACCR_OFS_CH3_GAIN_TRIM)) begin
      gainTrim <= accr_mask(regWrData, ACCR_MASK_GAIN_TRIM);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phaseTrim <= ACCR_RST_PHASE_TRIM;
    end else if (regWrEn && pageHit && accr_hit(regAddr, ACCR_OFS_CH3_PHASE_TRIM)) begin
      phaseTrim <= accr_mask(regWrData, ACCR_MASK_FULL);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      inputSetup <= ACCR_RST_INPUT_SETUP;
    end else if (regWrEn && pageHit && accr_hit(regAddr, ACCR_OFS_CH4_INPUT_SETUP)) begin
      inputSetup <= accr_mask(regWrData, ACCR_MASK_INPUT_SETUP);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      analogGain <= ACCR_RST_ANALOG_GAIN;
    end else if (regWrEn && pageHit && accr_hit(regAddr, ACCR_OFS_CH4_ANALOG_GAIN)) begin
      analogGain <= accr_mask(regWrData, ACCR_MASK_ANALOG_GAIN);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      volume <= ACCR_RST_VOLUME;
    end else if (regWrEn && pageHit && accr_hit(regAddr, ACCR_OFS_CH4_VOLUME)) begin
      volume <= accr_mask(regWrData, ACCR_MASK_FULL);
    end
  end

  // ***************************************************************
  // Register reads
  // ***************************************************************
  // read decode, unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      if (!pageHit) begin
        regRdData <= 8'h00;
      end else if (accr_hit(regAddr, ACCR_OFS_CH3_GAIN_TRIM)) begin
        regRdData <= gainTrim;
      end else if (accr_hit(regAddr, ACCR_OFS_CH3_PHASE_TRIM)) begin
        regRdData <= phaseTrim;
      end else if (accr_hit(regAddr, ACCR_OFS_CH4_INPUT_SETUP)) begin
        regRdData <= inputSetup;
      end else if (accr_hit(regAddr, ACCR_OFS_CH4_ANALOG_GAIN)) begin
        regRdData <= analogGain;
      end else if (accr_hit(regAddr, ACCR_OFS_CH4_VOLUME)) begin
        regRdData <= volume;
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  // ***************************************************************
  // Decoded settings
  // ***************************************************************
  logic analogSrc; // Channel 4 uses an analog source
  logic boostEn; // Range boost enable bit

  // analog codes are 0 and 1
  assign analogSrc = (inputSetup[ACCR_POS_SRC_LSB +: 2] == ACCR_SRC_ANALOG_DIFF)
                  || (inputSetup[ACCR_POS_SRC_LSB +: 2] == ACCR_SRC_ANALOG_SE);
  assign boostEn = inputSetup[ACCR_POS_RBOOST];

  // Settings registered so outputs come from flip-flops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chanCfg <= '0;
      chanCfg.volHalfDb <= 9'h000;
      chanCfg.ch3TrimTenths <= 5'h00;
    end else begin
      chanCfg.lineInput <= inputSetup[ACCR_POS_LINE];
      chanCfg.source <= inputSetup[ACCR_POS_SRC_LSB +: 2];
      chanCfg.dcCoupled <= inputSetup[ACCR_POS_DC] & analogSrc;
      chanCfg.impedance <= analogSrc ? inputSetup[ACCR_POS_IMP_LSB +: 2] : 2'h0;
      chanCfg.rangeEnhancerOn <= boostEn & ~gainLoopSelect;
      chanCfg.autoGainLoopOn <= boostEn & gainLoopSelect;
      chanCfg.gainDb <= analogGain[ACCR_POS_GAIN_LSB +: 6];
      chanCfg.volMute <= (volume == ACCR_VOL_MUTE);
      chanCfg.volHalfDb <= 9'({1'b0, volume} - ACCR_VOL_ZERO);
      chanCfg.ch3TrimTenths <= 5'({1'b0, gainTrim[ACCR_POS_TRIM_LSB +: 4]} - ACCR_TRIM_ZERO);
    end
  end

  // ***************************************************************
  // Channel 3 phase delay
  // ***************************************************************
  typedef enum logic {ACCR_PH_IDLE, ACCR_PH_WAIT} accr_ph_t;
  accr_ph_t phState; // Delay state
  logic [7:0] phCount; // Modulator cycles left

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phState <= ACCR_PH_IDLE;
      phCount <= 8'h00;
      ch3SampleOut <= 1'b0;
    end else begin
      ch3SampleOut <= 1'b0;
      case (phState)
        ACCR_PH_IDLE: begin
          // New event starts a delay or passes straight through
          if (ch3SampleIn) begin
            if (phaseTrim == 8'h00) begin
              ch3SampleOut <= 1'b1;
            end else begin
              phCount <= phaseTrim;
              phState <= ACCR_PH_WAIT;
            end
          end
        end
        ACCR_PH_WAIT: begin
          // Fire on the tick that ends the last cycle
          if (modTick) begin
            if (phCount == 8'h01) begin
              ch3SampleOut <= 1'b1;
              phState <= ACCR_PH_IDLE;
            end
            phCount <= phCount - 8'h01;
          end
        end
        default: begin
          phState <= ACCR_PH_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking accr_cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [8:0] chkTicks; // Ticks seen during a delay
  logic [7:0] chkCode; // Code latched at delay start
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chkTicks <= 9'h000;
      chkCode <= 8'h00;
    end else if (phState == ACCR_PH_IDLE && ch3SampleIn) begin
      chkTicks <= 9'h000;
      chkCode <= phaseTrim;
    end else if (phState == ACCR_PH_WAIT && modTick) begin
      chkTicks <= chkTicks + 9'h001;
    end
  end

  sequence accr_start_s;
    phState == ACCR_PH_IDLE && ch3SampleIn;
  endsequence
  sequence accr_zero_s;
    accr_start_s and (phaseTrim == 8'h00);
  endsequence

  chk_trim_decode: assert property (##1 chanCfg.ch3TrimTenths == 5'($past(gainTrim[7:4]) - 4'h8)) else $error("trim decode wrong");
  chk_reset_values: assert property (disable iff (1'b0) !rst_n |=> gainTrim == 8'h80 && volume == 8'hC9 && phaseTrim == 8'h00 && inputSetup == 8'h00) else $error("reset value wrong");
  chk_phase_count: assert property ($rose(ch3SampleOut) && chkCode != 8'h00 |-> chkTicks == {1'b0, chkCode}) else $error("phase delay length wrong");
  chk_phase_zero: assert property (accr_zero_s |=> ch3SampleOut) else $error("zero code delayed");
  chk_coupling_analog: assert property (chanCfg.dcCoupled |-> chanCfg.source < 2'h2) else $error("coupling on digital source");
  chk_boost_select: assert property (##1 (chanCfg.rangeEnhancerOn || chanCfg.autoGainLoopOn) == $past(boostEn) && !(chanCfg.rangeEnhancerOn && chanCfg.autoGainLoopOn)) else $error("enhancer select wrong");
  chk_gain_decode: assert property (##1 chanCfg.gainDb == $past(analogGain[7:2])) else $error("gain decode wrong");
  chk_page_guard: assert property (regWrEn && regPage != 8'h00 |=> $stable(volume) && $stable(inputSetup)) else $error("write on other page");
  chk_volume_mute: assert property (regWrEn && pageHit && regAddr == ACCR_OFS_CH4_VOLUME && regWrData == ACCR_VOL_MUTE |=> ##1 chanCfg.volMute) else $error("volume zero not muted");
  chk_reserved_zero: assert property (inputSetup[1] == 1'b0 && analogGain[1:0] == 2'h0 && gainTrim[3:0] == 4'h0) else $error("reserved bit set");

endmodule : accr_channel_regs

// >>> testbench/testbench.sv
// Self-checking bench for the channel configuration register bank.
// Assumes accr_pkg is compiled first; the bench alone drives every input.
`timescale 1ns/10ps
module testbench;
  import accr_pkg::*;
  // ***************************************************************
  // Stimulus and observed signals
  // ***************************************************************
  logic mclk = 1'b0; // 25 MHz clock
  logic rst_n = 1'b0; // Synchronous reset, active low
  logic [7:0] regPage = 8'h00; // Access page
  logic [7:0] regAddr = 8'h00; // Access address
  logic regWrEn = 1'b0; // Write strobe
  logic [7:0] regWrData = 8'h00; // Write data
  logic regRdEn = 1'b0; // Read strobe
  logic [7:0] regRdData; // Read data
  logic gainLoopSelect = 1'b0; // Enhancer or gain loop choice
  logic modTick = 1'b0; // Modulator cycle pulse
  logic ch3SampleIn = 1'b0; // Sampling event in
  logic ch3SampleOut; // Delayed sampling event
  accr_cfg_t chanCfg; // Decoded settings
  int n_errors = 0; // Mismatches
  int cmp_count = 0; // Comparisons
  accr_channel_regs accr_channel_regs_inst (.mclk(mclk), .rst_n(rst_n), .regPage(regPage),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .gainLoopSelect(gainLoopSelect), .modTick(modTick),
    .ch3SampleIn(ch3SampleIn), .ch3SampleOut(ch3SampleOut), .chanCfg(chanCfg));
  // Clock generator, 40 ns period
  initial begin
    forever #20 mclk = ~mclk;
  end
  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  // Compare one value and count it
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One single-byte write, strobe held for one taking edge
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regPage <= pg;
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask : wr
  // One read, data judged after the taking edge settles
  task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regPage <= pg;
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1;
    chk("read data", {1'b0, exp}, {1'b0, regRdData});
  endtask : rd
  // Let the decoded settings catch up with the registers
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  // Reset values, other pages and unmapped places
  task automatic t_reset();
    rd(8'h00, ACCR_OFS_CH3_GAIN_TRIM, 8'h80);
    rd(8'h00, ACCR_OFS_CH3_PHASE_TRIM, 8'h00);
    rd(8'h00, ACCR_OFS_CH4_INPUT_SETUP, 8'h00);
    rd(8'h00, ACCR_OFS_CH4_ANALOG_GAIN, 8'h00);
    rd(8'h00, ACCR_OFS_CH4_VOLUME, 8'hC9);
    wr(8'h01, ACCR_OFS_CH4_VOLUME, 8'h00);
    rd(8'h01, ACCR_OFS_CH4_VOLUME, 8'h00);
    rd(8'h00, ACCR_OFS_CH4_VOLUME, 8'hC9);
    rd(8'h00, 8'h4E, 8'h00);
  endtask : t_reset
  // Reserved bits read back zero
  task automatic t_reserved();
    // reserved bits set, field codes kept legal
    wr(8'h00, ACCR_OFS_CH3_GAIN_TRIM, 8'hFF);
    rd(8'h00, ACCR_OFS_CH3_GAIN_TRIM, 8'hF0);
    wr(8'h00, ACCR_OFS_CH4_INPUT_SETUP, 8'hDB);
    rd(8'h00, ACCR_OFS_CH4_INPUT_SETUP, 8'hD9);
    wr(8'h00, ACCR_OFS_CH4_ANALOG_GAIN, 8'hAB);
    rd(8'h00, ACCR_OFS_CH4_ANALOG_GAIN, 8'hA8);
  endtask : t_reserved
  // Every legal source, coupling and impedance only for analog
  task automatic t_source();
    logic an;
    // shared pins taken as freed before analog codes
    for (int s = 0; s < 3; s++) begin
      an = (s < 2);
      wr(8'h00, ACCR_OFS_CH4_INPUT_SETUP, {1'b1, 2'(s), 1'b1, 2'h2, 2'h0});
      settle();
      chk("source", 9'(s), 9'(chanCfg.source));
      chk("line", 9'h001, 9'(chanCfg.lineInput));
      chk("coupling", 9'(an), 9'(chanCfg.dcCoupled));
      chk("impedance", an ? 9'h002 : 9'h000, 9'(chanCfg.impedance));
    end
  endtask : t_source
  // Enable bit with both choices of the loop select
  task automatic t_enable();
    wr(8'h00, ACCR_OFS_CH4_INPUT_SETUP, 8'h01);
    for (int g = 0; g < 2; g++) begin
      @(posedge mclk);
      gainLoopSelect <= g[0];
      settle();
      chk("enhancer", 9'(!g[0]), 9'(chanCfg.rangeEnhancerOn));
      chk("gain loop", 9'(g[0]), 9'(chanCfg.autoGainLoopOn));
    end
    wr(8'h00, ACCR_OFS_CH4_INPUT_SETUP, 8'h00);
    settle();
    chk("both off", 9'h000, 9'({chanCfg.rangeEnhancerOn, chanCfg.autoGainLoopOn}));
  endtask : t_enable
  // Gain code 42, volume and trim boundary codes
  task automatic t_codes();
    wr(8'h00, ACCR_OFS_CH4_ANALOG_GAIN, 8'hA8);
    wr(8'h00, ACCR_OFS_CH4_VOLUME, 8'h00);
    wr(8'h00, ACCR_OFS_CH3_GAIN_TRIM, 8'h00);
    settle();
    chk("gain 42", 9'h02A, 9'(chanCfg.gainDb));
    chk("mute", 9'h001, 9'(chanCfg.volMute));
    chk("trim low", 9'h018, 9'(chanCfg.ch3TrimTenths));
    wr(8'h00, ACCR_OFS_CH4_VOLUME, 8'hFF);
    wr(8'h00, ACCR_OFS_CH3_GAIN_TRIM, 8'hF0);
    settle();
    chk("vol top", 9'h036, chanCfg.volHalfDb);
    chk("unmuted", 9'h000, 9'(chanCfg.volMute));
    chk("trim high", 9'h007, 9'(chanCfg.ch3TrimTenths));
  endtask : t_codes
  // Reset in mid-run returns written registers and decodes to reset values
  task automatic t_rereset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h00, ACCR_OFS_CH4_VOLUME, 8'hC9);
    rd(8'h00, ACCR_OFS_CH3_GAIN_TRIM, 8'h80);
    rd(8'h00, ACCR_OFS_CH4_ANALOG_GAIN, 8'h00);
    chk("vol after reset", 9'h000, chanCfg.volHalfDb);
    chk("trim after reset", 9'h000, 9'(chanCfg.ch3TrimTenths));
  endtask : t_rereset
  // Phase delay: ticks every third cycle, one pulse the cycle after tick n
  task automatic t_phase(input int n);
    int seen;
    int at;
    seen = 0;
    at = 0;
    wr(8'h00, ACCR_OFS_CH3_PHASE_TRIM, 8'(n));
    ch3SampleIn <= 1'b1;
    for (int k = 1; k <= 3 * n + 4; k++) begin
      @(posedge mclk);
      ch3SampleIn <= 1'b0;
      modTick <= ((k % 3) == 0);
      #1;
      // Pulse seen here is sampled at edge k counted from the start edge
      if (ch3SampleOut === 1'b1) begin
        seen++;
        at = k;
      end
    end
    chk("pulse count", 9'h001, 9'(seen));
    chk("pulse cycle", (n == 0) ? 9'h001 : 9'(3 * n + 1), 9'(at));
  endtask : t_phase
  // ***************************************************************
  // Verdict, watchdog and main sequence
  // ***************************************************************
  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // Watchdog well beyond the roughly 900 cycles the run needs
  initial begin
    #(40 * 6000);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_reserved();
    t_source();
    t_enable();
    t_codes();
    t_rereset();
    t_phase(0);
    t_phase(1);
    t_phase(2);
    t_phase(255);
    close_out();
  end
endmodule : testbench
